// ===== attach_seq_pkg.sv
// package: offsets, field positions, timing constants and states of the attach sequencer
package attach_seq_pkg;

  // clock rate and documented waits
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned SETTLE_MS      = 100;
  localparam int unsigned BUS_RESET_MS   = 50;
  localparam int unsigned RECOVER_MS     = 10;
  localparam int unsigned SETTLE_CYC     = SETTLE_MS * CYC_PER_MS;
  localparam int unsigned BUS_RESET_CYC  = BUS_RESET_MS * CYC_PER_MS;
  localparam int unsigned RECOVER_CYC    = RECOVER_MS * CYC_PER_MS;

  // device register map, reached over the device's own register port
  localparam logic [3:0] DEV_USB_CONTROL  = 4'h0;
  localparam logic [3:0] DEV_OTG_CONTROL  = 4'h1;
  localparam logic [3:0] DEV_IRQ_ENABLE   = 4'h2;
  localparam logic [3:0] DEV_IRQ_FLAG     = 4'h3;
  localparam logic [3:0] DEV_USB_ADDRESS  = 4'h4;
  localparam logic [3:0] DEV_EP0_CONTROL  = 4'h5;

  // device field positions
  localparam int unsigned FRAME_MARKER_ENABLE_BIT   = 0;
  localparam int unsigned HOST_MODE_ENABLE_BIT      = 3;
  localparam int unsigned BUS_RESET_DRIVE_BIT       = 4;
  localparam int unsigned LINE_J_STATE_BIT          = 7;
  localparam int unsigned DMINUS_PULLDOWN_ENABLE_BIT = 4;
  localparam int unsigned DPLUS_PULLDOWN_ENABLE_BIT = 5;
  localparam int unsigned DMINUS_PULLUP_ENABLE_BIT  = 6;
  localparam int unsigned DPLUS_PULLUP_ENABLE_BIT   = 7;
  localparam int unsigned ATTACH_IRQ_ENABLE_BIT     = 6;
  localparam int unsigned ATTACH_FLAG_BIT           = 6;
  localparam int unsigned TRANSFER_DONE_FLAG_BIT    = 3;
  localparam int unsigned LOW_SPEED_ENABLE_BIT      = 7;
  localparam int unsigned LOW_SPEED_EP_SELECT_BIT   = 7;

  // own software-facing register map
  localparam logic [3:0] SW_CTRL     = 4'h0;
  localparam logic [3:0] SW_STATUS   = 4'h1;
  localparam logic [3:0] SW_RAW_ADDR = 4'h2;
  localparam logic [3:0] SW_RAW_DATA = 4'h3;
  localparam logic [3:0] SW_RAW_CMD  = 4'h4;
  localparam logic [3:0] SW_STATE    = 4'h5;

  localparam int unsigned CTRL_START_BIT   = 0;
  localparam int unsigned CTRL_ABORT_BIT   = 1;
  localparam int unsigned RAW_WRITE_BIT    = 0;
  localparam int unsigned RAW_READ_BIT     = 1;
  localparam int unsigned ST_BUSY_BIT      = 0;
  localparam int unsigned ST_DONE_BIT      = 1;
  localparam int unsigned ST_LOW_SPEED_BIT = 2;
  localparam int unsigned ST_ATTACHED_BIT  = 3;
  localparam int unsigned ST_XFER_DONE_BIT = 4;
  localparam int unsigned ST_ABORTED_BIT   = 5;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [4:0] {
    S_IDLE, S_HOST_ON, S_PULLS, S_QUIET, S_IRQ_EN, S_POLL_RD, S_POLL_WAIT,
    S_CLR_FLAG, S_SETTLE, S_LINE_RD, S_LINE_WAIT, S_LS_ADDR, S_LS_EP0,
    S_RST_ON, S_RST_HOLD, S_RST_OFF, S_SOF_ON, S_RECOVER, S_ABORT,
    S_RAW_GO, S_RAW_WAIT
  } seq_state_t;

endpackage

// ===== seq_timer.sv
// down-counting wait timer, loaded by the sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_timer import attach_seq_pkg::*; #(
  parameter int unsigned CNT_W = 22
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  expired
);

  logic [CNT_W-1:0] cnt_r;

  if (CNT_W < 2) begin : g_chk
    $error("seq_timer: CNT_W too small");
  end

  // load value minus one so a wait of n cycles expires n cycles after load
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= (load_val == '0) ? '0 : load_val - 1'b1;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign expired = (cnt_r == '0);

endmodule
`default_nettype wire

// ===== dev_access.sv
// one-request register port master toward the device, all outputs registered
`timescale 1ns/1ps
`default_nettype none
module dev_access import attach_seq_pkg::*; #(
  parameter int unsigned ADDR_W = 4,
  parameter int unsigned DATA_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              req_wr,
  input  wire logic              req_rd,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [DATA_W-1:0] dev_rdata,
  output logic      [ADDR_W-1:0] dev_addr,
  output logic      [DATA_W-1:0] dev_wdata,
  output logic                   dev_wr,
  output logic                   dev_rd,
  output logic                   rd_valid,
  output logic      [DATA_W-1:0] rd_data
);

  // strobes last one cycle; address and data hold until the next request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dev_addr  <= '0;
      dev_wdata <= '0;
      dev_wr    <= 1'b0;
      dev_rd    <= 1'b0;
    end else begin
      dev_wr <= req_wr;
      dev_rd <= req_rd & ~req_wr; // a write wins, never both strobes
      if (req_wr | req_rd) begin
        dev_addr  <= req_addr;
        dev_wdata <= req_wdata;
      end
    end
  end

  logic rd_pend_r;

  // device answers in the cycle after its read strobe; sampling at the strobe's
  // own edge would catch the stale bus, so wait one cycle and take it then
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_pend_r <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
    end else begin
      rd_pend_r <= dev_rd;
      rd_valid  <= rd_pend_r;
      if (rd_pend_r) begin
        rd_data <= dev_rdata;
      end
    end
  end

endmodule
`default_nettype wire

// ===== usb_host_attach_sequencer.sv
// host bring-up sequencer: drives the usb controller's registers through attach and reset
//
// Notes on behaviour
// RULE1 - all transfers use endpoint zero and descriptors
// RULE2 - software starts transfers and handles handshakes
// RULE3 - host_mode_enable unlocks host-only control bits
// RULE4 - pull-downs on, pull-ups off before attach
// RULE5 - host mode starts frames, counter at 12,000
// RULE6 - clear frame_marker_enable to quiet bus
// RULE7 - set attach_irq_enable for attach interrupt
// RULE8 - attach flag set on SE0 to J
// RULE9 - wait 100 ms after attach for power
// RULE10 - line_j_state low after attach means low speed
// RULE11 - low speed: set address and ep0 bits
// RULE12 - bus reset held at least 50 ms; an abort during the hold cuts it short
// RULE13 - re-enable frames after reset ends
// RULE14 - wait 10 ms for device reset recovery
// RULE15 - then enumerate with standard requests
// RULE16 - transfer completion sets transfer_done_flag
// RULE17 - attach flag sticky; reset drives SE0
// RULE18 - frames off still reports line and attach
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module usb_host_attach_sequencer import attach_seq_pkg::*; #(
  parameter int unsigned CNT_W         = 22,
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned RESET_CYCLES  = BUS_RESET_CYC,
  parameter int unsigned RECOV_CYCLES  = RECOVER_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // software port
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic      [7:0] sw_rdata,
  // device register port
  output logic      [3:0] dev_addr,
  output logic      [7:0] dev_wdata,
  output logic            dev_wr,
  output logic            dev_rd,
  input  wire logic [7:0] dev_rdata
);

  // elaboration check: every wait must fit the timer
  if (SETTLE_CYCLES >= (64'd1 << CNT_W) || RESET_CYCLES >= (64'd1 << CNT_W) ||
      RECOV_CYCLES >= (64'd1 << CNT_W) || SETTLE_CYCLES == 0 ||
      RESET_CYCLES == 0 || RECOV_CYCLES == 0) begin : g_chk
    $error("usb_host_attach_sequencer: wait counts do not fit CNT_W");
  end

  // one-hot byte for a field position
  function automatic logic [7:0] fld(input int unsigned pos);
    fld = 8'h01 << pos[2:0];
  endfunction

  seq_state_t state_r;
  seq_state_t state_nxt;

  logic       req_wr;
  logic       req_rd;
  logic [3:0] req_addr;
  logic [7:0] req_wdata;
  logic       rd_valid;
  logic [7:0] rd_data;
  logic       tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic       tmr_expired;

  logic       start_cmd;
  logic       abort_cmd;
  logic       raw_cmd;
  logic       done_r;
  logic       aborted_r;
  logic       low_speed_r;
  logic       attached_r;
  logic       xfer_done_r;
  logic [3:0] raw_addr_r;
  logic [7:0] raw_data_r;
  logic       raw_is_rd_r;
  logic [7:0] raw_rdata_r;
  logic [7:0] rdata_nxt;

  wire logic busy = (state_r != S_IDLE);

  // decoded software commands
  assign start_cmd = sw_wr && sw_addr == SW_CTRL && sw_wdata[CTRL_START_BIT];
  assign abort_cmd = sw_wr && sw_addr == SW_CTRL && sw_wdata[CTRL_ABORT_BIT];
  assign raw_cmd   = sw_wr && sw_addr == SW_RAW_CMD &&
                     (sw_wdata[RAW_WRITE_BIT] | sw_wdata[RAW_READ_BIT]);

  dev_access #(
    .ADDR_W (4),
    .DATA_W (8)
  ) u_dev (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .req_wr    (req_wr),
    .req_rd    (req_rd),
    .req_addr  (req_addr),
    .req_wdata (req_wdata),
    .dev_rdata (dev_rdata),
    .dev_addr  (dev_addr),
    .dev_wdata (dev_wdata),
    .dev_wr    (dev_wr),
    .dev_rd    (dev_rd),
    .rd_valid  (rd_valid),
    .rd_data   (rd_data)
  );

  seq_timer #(
    .CNT_W (CNT_W)
  ) u_tmr (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_expired)
  );

  // next state and the single device request issued in each step
  always_comb begin
    state_nxt = state_r;
    req_wr    = 1'b0;
    req_rd    = 1'b0;
    req_addr  = DEV_USB_CONTROL;
    req_wdata = BYTE_ZERO;
    tmr_load  = 1'b0;
    tmr_val   = '0;
    case (state_r)
      S_IDLE: begin
        if (start_cmd) begin
          state_nxt = S_HOST_ON;
        end else if (raw_cmd) begin
          state_nxt = S_RAW_GO;
        end
      end
      S_HOST_ON: begin
        // host mode on; frame markers are switched on in the same write
        req_wr    = 1'b1;
        req_wdata = fld(HOST_MODE_ENABLE_BIT) | fld(FRAME_MARKER_ENABLE_BIT); // RULE3 RULE5
        state_nxt = S_PULLS;
      end
      S_PULLS: begin
        req_wr    = 1'b1;
        req_addr  = DEV_OTG_CONTROL;
        req_wdata = fld(DPLUS_PULLDOWN_ENABLE_BIT) | fld(DMINUS_PULLDOWN_ENABLE_BIT); // RULE4
        state_nxt = S_QUIET;
      end
      S_QUIET: begin
        // no frames while waiting, so the idle bus stays noise free
        req_wr    = 1'b1;
        req_wdata = fld(HOST_MODE_ENABLE_BIT); // RULE6
        state_nxt = S_IRQ_EN;
      end
      S_IRQ_EN: begin
        req_wr    = 1'b1;
        req_addr  = DEV_IRQ_ENABLE;
        req_wdata = fld(ATTACH_IRQ_ENABLE_BIT); // RULE7
        state_nxt = S_POLL_RD;
      end
      S_POLL_RD: begin
        // the flag is polled rather than taken as an interrupt line
        req_rd    = 1'b1;
        req_addr  = DEV_IRQ_FLAG;
        state_nxt = S_POLL_WAIT;
      end
      S_POLL_WAIT: begin
        if (rd_valid) begin
          state_nxt = rd_data[ATTACH_FLAG_BIT] ? S_CLR_FLAG : S_POLL_RD; // RULE8 RULE17
        end
      end
      S_CLR_FLAG: begin
        // flag is sticky in the device, cleared by writing one
        req_wr    = 1'b1;
        req_addr  = DEV_IRQ_FLAG;
        req_wdata = fld(ATTACH_FLAG_BIT); // RULE17
        tmr_load  = 1'b1;
        tmr_val   = CNT_W'(SETTLE_CYCLES); // RULE9
        state_nxt = S_SETTLE;
      end
      S_SETTLE: begin
        if (tmr_expired) begin
          state_nxt = S_LINE_RD;
        end
      end
      S_LINE_RD: begin
        req_rd    = 1'b1;
        state_nxt = S_LINE_WAIT;
      end
      S_LINE_WAIT: begin
        if (rd_valid) begin
          state_nxt = rd_data[LINE_J_STATE_BIT] ? S_RST_ON : S_LS_ADDR; // RULE10 RULE18
        end
      end
      S_LS_ADDR: begin
        req_wr    = 1'b1;
        req_addr  = DEV_USB_ADDRESS;
        req_wdata = fld(LOW_SPEED_ENABLE_BIT); // RULE11
        state_nxt = S_LS_EP0;
      end
      S_LS_EP0: begin
        req_wr    = 1'b1;
        req_addr  = DEV_EP0_CONTROL;
        req_wdata = fld(LOW_SPEED_EP_SELECT_BIT); // RULE11 RULE1
        state_nxt = S_RST_ON;
      end
      S_RST_ON: begin
        req_wr    = 1'b1;
        req_wdata = fld(HOST_MODE_ENABLE_BIT) | fld(BUS_RESET_DRIVE_BIT); // RULE12 RULE17
        tmr_load  = 1'b1;
        tmr_val   = CNT_W'(RESET_CYCLES);
        state_nxt = S_RST_HOLD;
      end
      S_RST_HOLD: begin
        if (abort_cmd || tmr_expired) begin
          state_nxt = S_RST_OFF; // RULE12
        end
      end
      S_RST_OFF: begin
        // an abort still ends the reset cleanly rather than leaving SE0 on
        req_wr    = 1'b1;
        req_wdata = fld(HOST_MODE_ENABLE_BIT);
        state_nxt = aborted_r ? S_IDLE : S_SOF_ON;
      end
      S_SOF_ON: begin
        req_wr    = 1'b1;
        req_wdata = fld(HOST_MODE_ENABLE_BIT) | fld(FRAME_MARKER_ENABLE_BIT); // RULE13
        tmr_load  = 1'b1;
        tmr_val   = CNT_W'(RECOV_CYCLES); // RULE14
        state_nxt = S_RECOVER;
      end
      S_RECOVER: begin
        if (tmr_expired) begin
          state_nxt = S_IDLE; // RULE15
        end
      end
      S_ABORT: begin
        req_wr    = 1'b1;
        req_wdata = fld(HOST_MODE_ENABLE_BIT);
        state_nxt = S_IDLE;
      end
      S_RAW_GO: begin
        // software-driven access for endpoint-zero transfers and descriptors
        req_wr    = ~raw_is_rd_r; // RULE2
        req_rd    = raw_is_rd_r;
        req_addr  = raw_addr_r;
        req_wdata = raw_data_r;
        state_nxt = raw_is_rd_r ? S_RAW_WAIT : S_IDLE;
      end
      S_RAW_WAIT: begin
        if (rd_valid) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    // abort leaves any step except the reset pair and raw accesses
    if (abort_cmd && state_r != S_IDLE && state_r != S_RST_HOLD &&
        state_r != S_RST_OFF && state_r != S_ABORT && state_r != S_RAW_GO &&
        state_r != S_RAW_WAIT) begin
      state_nxt = S_ABORT;
    end
  end

  // sequencer state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // sequence outcome flags; a hardware set wins over a clear by start
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      done_r      <= 1'b0;
      aborted_r   <= 1'b0;
      attached_r  <= 1'b0;
      low_speed_r <= 1'b0;
    end else begin
      if (state_r == S_RECOVER && tmr_expired) begin
        done_r <= 1'b1;
      end else if (start_cmd && !busy) begin
        done_r <= 1'b0;
      end
      if (abort_cmd && busy) begin
        aborted_r <= 1'b1;
      end else if (start_cmd && !busy) begin
        aborted_r <= 1'b0;
      end
      if (state_r == S_POLL_WAIT && rd_valid && rd_data[ATTACH_FLAG_BIT]) begin
        attached_r <= 1'b1;
      end else if (start_cmd && !busy) begin
        attached_r <= 1'b0;
      end
      if (state_r == S_LINE_WAIT && rd_valid) begin
        low_speed_r <= ~rd_data[LINE_J_STATE_BIT]; // RULE10
      end else if (start_cmd && !busy) begin
        low_speed_r <= 1'b0;
      end
    end
  end

  // raw access registers and the transfer-complete watch
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      raw_addr_r  <= 4'h0;
      raw_data_r  <= BYTE_ZERO;
      raw_is_rd_r <= 1'b0;
      raw_rdata_r <= BYTE_ZERO;
      xfer_done_r <= 1'b0;
    end else begin
      if (sw_wr && sw_addr == SW_RAW_ADDR) begin
        raw_addr_r <= sw_wdata[3:0];
      end
      if (sw_wr && sw_addr == SW_RAW_DATA) begin
        raw_data_r <= sw_wdata;
      end
      if (raw_cmd && !busy) begin
        raw_is_rd_r <= sw_wdata[RAW_READ_BIT];
      end
      if (state_r == S_RAW_WAIT && rd_valid) begin
        raw_rdata_r <= rd_data;
      end
      // a raw read of the flag register shows transfer completion
      if (state_r == S_RAW_WAIT && rd_valid && raw_addr_r == DEV_IRQ_FLAG &&
          rd_data[TRANSFER_DONE_FLAG_BIT]) begin
        xfer_done_r <= 1'b1; // RULE16
      end else if (raw_cmd && !busy) begin
        xfer_done_r <= 1'b0;
      end
    end
  end

  // software read mux, answered in the next cycle
  always_comb begin
    rdata_nxt = BYTE_ZERO;
    case (sw_addr)
      SW_STATUS: begin
        rdata_nxt[ST_BUSY_BIT]      = busy;
        rdata_nxt[ST_DONE_BIT]      = done_r;
        rdata_nxt[ST_LOW_SPEED_BIT] = low_speed_r;
        rdata_nxt[ST_ATTACHED_BIT]  = attached_r;
        rdata_nxt[ST_XFER_DONE_BIT] = xfer_done_r;
        rdata_nxt[ST_ABORTED_BIT]   = aborted_r;
      end
      SW_RAW_ADDR: rdata_nxt = {4'h0, raw_addr_r};
      SW_RAW_DATA: rdata_nxt = raw_rdata_r;
      SW_STATE:    rdata_nxt = {3'h0, state_r};
      default:     rdata_nxt = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sw_rdata <= BYTE_ZERO;
    end else begin
      sw_rdata <= sw_rd ? rdata_nxt : BYTE_ZERO;
    end
  end

endmodule
`default_nettype wire

// ===== attach_seq_sva.sv
// checker: device-port sequencing and software read-window properties of the attach sequencer
`timescale 1ns/1ps
`default_nettype none
module attach_seq_sva import attach_seq_pkg::*; #(
  parameter int unsigned SETTLE_CYCLES = 20,
  parameter int unsigned RESET_CYCLES  = 10
) (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       sw_rd,
  input wire logic [7:0] sw_rdata,
  input wire logic [3:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic       dev_wr,
  input wire logic       dev_rd
);
  logic        rst_on_r;
  int unsigned rst_cnt_r;
  int unsigned flag_cnt_r;
  wire ctl_wr = dev_wr && dev_addr == DEV_USB_CONTROL;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // length of the current bus reset, counted from the write that starts it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rst_on_r  <= 1'b0;
      rst_cnt_r <= 0;
    end else if (ctl_wr) begin
      rst_on_r  <= dev_wdata[4];
      rst_cnt_r <= 0;
    end else begin
      rst_cnt_r <= rst_cnt_r + 1;
    end
  end

  // cycles since the attach flag was last cleared
  always_ff @(posedge ref_clk) begin
    if (reset || (dev_wr && dev_addr == DEV_IRQ_FLAG)) begin
      flag_cnt_r <= 0;
    end else begin
      flag_cnt_r <= flag_cnt_r + 1;
    end
  end

  chk_strobe_excl: assert property (!(dev_wr && dev_rd))
    else $error("device read and write strobes together");
  chk_read_gap: assert property (dev_rd |=> !dev_rd && !dev_wr)
    else $error("device request while read answer pending");
  chk_rdata_window: assert property (!$past(sw_rd) |-> sw_rdata == BYTE_ZERO)
    else $error("software read data outside its cycle");
  chk_host_kept: assert property (ctl_wr |-> dev_wdata[3])
    else $error("control write drops host mode");
  chk_pulls_value: assert property (dev_wr && dev_addr == DEV_OTG_CONTROL |->
    dev_wdata[5:4] == 2'b11 && dev_wdata[7:6] == 2'b00)
    else $error("pull resistor setting wrong");
  chk_attach_ie: assert property (dev_wr && dev_addr == DEV_IRQ_ENABLE |-> dev_wdata[6])
    else $error("attach interrupt enable not set");
  chk_settle_wait: assert property (dev_rd && dev_addr == DEV_USB_CONTROL |->
    flag_cnt_r >= SETTLE_CYCLES)
    else $error("line state read before settle time");
  chk_ls_pair: assert property (dev_wr && dev_addr == DEV_USB_ADDRESS |-> dev_wdata[7]
    ##[1:4] (dev_wr && dev_addr == DEV_EP0_CONTROL && dev_wdata[7]))
    else $error("low speed selection incomplete");
  chk_reset_len: assert property (ctl_wr && !dev_wdata[4] && rst_on_r |->
    rst_cnt_r >= RESET_CYCLES)
    else $error("bus reset ended too early");
  chk_frames_back: assert property (ctl_wr && !dev_wdata[4] && rst_on_r |->
    ##[1:4] (ctl_wr && dev_wdata[0]))
    else $error("frames not re-enabled after bus reset");

  cov_attach_seen: cover property (dev_wr && dev_addr == DEV_IRQ_FLAG);
  cov_low_speed: cover property (dev_wr && dev_addr == DEV_USB_ADDRESS);
  cov_reset_end: cover property (ctl_wr && !dev_wdata[4] && rst_on_r);
endmodule
`default_nettype wire

// ===== usb_dev_model.sv
// model of the usb controller registers seen through the device register port
`timescale 1ns/1ps
`default_nettype none
module usb_dev_model import attach_seq_pkg::*; (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [3:0] dev_addr,
  input  wire logic [7:0] dev_wdata,
  input  wire logic       dev_wr,
  input  wire logic       dev_rd,
  input  wire logic       plug,
  input  wire logic       slow,
  input  wire logic       xfer,
  output logic      [7:0] dev_rdata,
  output logic            se0_drive,
  output logic            frames_on
);
  localparam int unsigned FRAME_LOAD = 12000;
  logic [7:0] ctrl_r, otg_r, ie_r, flag_r, addr_r, ep0_r;
  logic       attached_r;
  int unsigned frame_cnt_r;

  // host-only bits act only with host mode on
  assign se0_drive = ctrl_r[4] & ctrl_r[3];
  assign frames_on = ctrl_r[0] & ctrl_r[3] & ~ctrl_r[4];

  // plain registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      {ctrl_r, otg_r, ie_r, addr_r, ep0_r} <= '0;
    end else if (dev_wr) begin
      case (dev_addr)
        DEV_USB_CONTROL: ctrl_r <= dev_wdata;
        DEV_OTG_CONTROL: otg_r <= dev_wdata;
        DEV_IRQ_ENABLE:  ie_r <= dev_wdata;
        DEV_USB_ADDRESS: addr_r <= dev_wdata;
        DEV_EP0_CONTROL: ep0_r <= dev_wdata;
        default: ;
      endcase
    end
  end

  // frame counter restarts at the full load when host mode comes on
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frame_cnt_r <= 0;
    end else if (dev_wr && dev_addr == DEV_USB_CONTROL && dev_wdata[3] && !ctrl_r[3]) begin
      frame_cnt_r <= FRAME_LOAD;
    end else if (frames_on) begin
      frame_cnt_r <= (frame_cnt_r == 0) ? FRAME_LOAD : frame_cnt_r - 1;
    end
  end

  // event flags: hardware set wins over a write-one clear, flags stay until cleared
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flag_r     <= '0;
      attached_r <= 1'b0;
    end else begin
      if (dev_wr && dev_addr == DEV_IRQ_FLAG) flag_r <= flag_r & ~dev_wdata;
      if (plug) flag_r[6] <= 1'b1;
      if (xfer) flag_r[3] <= 1'b1;
      if (plug) attached_r <= 1'b1;
    end
  end

  // answer in the cycle after the read, otherwise a toggling pattern
  always_ff @(posedge ref_clk) begin
    if (dev_rd) begin
      case (dev_addr)
        DEV_USB_CONTROL: dev_rdata <= {attached_r & ~slow, ctrl_r[6:0]};
        DEV_OTG_CONTROL: dev_rdata <= otg_r;
        DEV_IRQ_ENABLE:  dev_rdata <= ie_r;
        DEV_IRQ_FLAG:    dev_rdata <= flag_r;
        DEV_USB_ADDRESS: dev_rdata <= addr_r;
        DEV_EP0_CONTROL: dev_rdata <= ep0_r;
        default:         dev_rdata <= 8'h00;
      endcase
    end else begin
      dev_rdata <= ~dev_rdata;
    end
  end
endmodule
`default_nettype wire

// ===== usb_host_attach_sequencer_tb.sv
// testbench: software-port scenarios against the controller model
`timescale 1ns/1ps
`default_nettype none
module usb_host_attach_sequencer_tb;
  import attach_seq_pkg::*;
  localparam int unsigned SET = 20;
  localparam int unsigned RST = 10;
  localparam int unsigned REC = 5;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic       sw_wr = 1'b0;
  logic       sw_rd = 1'b0;
  logic [7:0] sw_rdata, dev_wdata, dev_rdata;
  logic [3:0] dev_addr;
  logic       dev_wr, dev_rd, se0_drive, frames_on;
  logic       plug = 1'b0;
  logic       slow = 1'b0;
  logic       xfer = 1'b0;
  int         err_count = 0;
  int         n_checks = 0;
  int         se0_cycles = 0;
  logic [7:0] st;

  usb_host_attach_sequencer #(.SETTLE_CYCLES(SET), .RESET_CYCLES(RST), .RECOV_CYCLES(REC)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata));
  usb_dev_model u_dev (
    .ref_clk(ref_clk), .reset(reset), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr(dev_wr), .dev_rd(dev_rd), .plug(plug), .slow(slow), .xfer(xfer),
    .dev_rdata(dev_rdata), .se0_drive(se0_drive), .frames_on(frames_on));

  always #25 ref_clk = ~ref_clk;
  // bus reset length seen on the wire
  always @(posedge ref_clk) if (se0_drive) se0_cycles <= se0_cycles + 1;

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic pulse(input bit is_xfer);
    @(posedge ref_clk);
    if (is_xfer) xfer <= 1'b1;
    else plug <= 1'b1;
    @(posedge ref_clk);
    xfer <= 1'b0;
    plug <= 1'b0;
  endtask

  // reset values, unmapped read, read-write raw address field
  task automatic t_regs;
    sw_read(SW_STATUS, st); check("status after reset", 8'h00, st);
    sw_read(SW_STATE, st); check("state after reset", 8'h00, st);
    sw_read(4'hf, st); check("unmapped read", 8'h00, st);
    sw_write(SW_RAW_ADDR, 8'h03);
    sw_read(SW_RAW_ADDR, st); check("raw address", 8'h03, st);
  endtask

  // full bring-up with a full or low speed device
  task automatic t_attach(input logic ls);
    int s0;
    s0 = se0_cycles;
    slow <= ls;
    sw_write(SW_CTRL, 8'h01);
    repeat (12) @(posedge ref_clk);
    check("control while quiet", 8'h08, u_dev.ctrl_r);
    sw_read(SW_STATUS, st); check("waiting status", 8'h01, st & 8'h0b);
    pulse(1'b0);
    for (int i = 0; i < 200; i++) begin
      sw_read(SW_STATUS, st);
      if (st[ST_DONE_BIT] === 1'b1) break;
    end
    check("done status", {5'h00, ls, 2'b10} | 8'h08, st & 8'h0f);
    check("pulls", 8'h30, u_dev.otg_r);
    check("attach enable", 8'h40, u_dev.ie_r & 8'h40);
    check("attach flag cleared", 8'h00, u_dev.flag_r & 8'h40);
    check("address low speed", {ls, 7'h00}, u_dev.addr_r & 8'h80);
    check("ep0 low speed", {ls, 7'h00}, u_dev.ep0_r & 8'h80);
    check("reset long enough", 8'h01, 8'(se0_cycles - s0 >= RST));
    check("frames running", 8'h01, {7'h00, frames_on});
  endtask

  // raw read of the flag register reports a completed transfer
  task automatic t_raw;
    pulse(1'b1);
    sw_write(SW_RAW_ADDR, {4'h0, DEV_IRQ_FLAG});
    sw_write(SW_RAW_CMD, 8'h02);
    repeat (6) @(posedge ref_clk);
    sw_read(SW_RAW_DATA, st); check("raw flag read", 8'h08, st);
    sw_read(SW_STATUS, st); check("transfer done", 8'h10, st & 8'h10);
  endtask

  // abort while waiting for a device leaves host mode on, frames off
  task automatic t_abort;
    sw_write(SW_CTRL, 8'h01);
    repeat (10) @(posedge ref_clk);
    sw_write(SW_CTRL, 8'h02);
    repeat (8) @(posedge ref_clk);
    sw_read(SW_STATUS, st); check("aborted status", 8'h20, st & 8'h21);
    check("control after abort", 8'h08, u_dev.ctrl_r);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_attach(1'b0);
    t_attach(1'b1);
    t_raw();
    t_abort();
    stop_test();
  end

  // hang guard, well past the few hundred cycles the scenarios need
  initial begin
    #(50 * 20000);
    err_count++;
    stop_test();
  end
endmodule
bind usb_host_attach_sequencer attach_seq_sva #(
  .SETTLE_CYCLES(SETTLE_CYCLES), .RESET_CYCLES(RESET_CYCLES)) u_sva (
  .ref_clk(ref_clk), .reset(reset), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dev_addr(dev_addr),
  .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd));
`default_nettype wire
